// ### rtl/ccr_pkg.sv
package ccr_pkg;
	// register indices: the first strobe of a pair hits A, the second B
	localparam logic FEAT_A_IDX = 1'b0;
	localparam logic FEAT_B_IDX = 1'b1;
	localparam logic [7:0] FEAT_A_RESET = 8'h00;
	localparam logic [7:0] FEAT_B_RESET = 8'h00;
	// feature_control_a fields
	localparam int A_VIDEO_SHADOW_BIT = 0;
	localparam int A_SHADOW_WRITE_BIT = 1;
	localparam int A_EARLY_CWR_BIT = 2;
	localparam int A_ROM_SIZE_BIT = 3;
	localparam int A_CWR_ZERO_WAIT_BIT = 4;
	localparam int A_CACHE_MODE_LSB = 5;
	localparam int A_CACHE_EN_BIT = 7;
	// feature_control_b fields
	localparam int B_MEM_SIZE_LSB = 0;
	localparam int B_RESERVED_BIT = 3;
	localparam int B_CAS_WAIT_LSB = 4;
	localparam int B_SHADOW_READ_BIT = 6;
	localparam int B_PAGE_MODE_BIT = 7;
	// hidden toggles
	localparam logic [15:0] REFRESH_TOGGLE_PORT = 16'h0822;
	localparam logic [2:0] REFRESH_RUN_LEN = 3'h3;
	localparam logic [2:0] SPEED_RUN_LEN = 3'h4;
	localparam logic REFRESH_RESET = 1'b1;
	localparam logic SPEED_DIV2_RESET = 1'b0;
	// 64K segment numbers (address bits 23:16)
	localparam logic [7:0] SEG_VIDEO = 8'h0c;
	localparam logic [7:0] SEG_VIDEO_HI = 8'h0d;
	localparam logic [7:0] SEG_BIOS_LO = 8'h0e;
	localparam logic [7:0] SEG_BIOS = 8'h0f;
	localparam logic [7:0] SEG_TOP_LO = 8'hfe;
	localparam logic [7:0] SEG_TOP = 8'hff;
	typedef enum logic [1:0] {
		CACHE_NONE,
		CACHE_EXT_32K,
		CACHE_EXT_64K_UP,
		CACHE_INTERNAL_128B
	} ccr_cache_mode_type;
endpackage : ccr_pkg

// ### rtl/ccr_config_regs.sv
`timescale 1ns/1ps
// How it works
// - select strobe with write/read moves config data
// - refresh on at power up; 3 reads toggle
// - clock div1 default; 4 config reads toggle
// - divider switches without glitch or runt
// - first strobe register A, second register B
// - both feature registers clear at power up
// - bit0 adds video shadow, 64K or 128K
// - second revision: bit3 picks 64K/128K both
// - first revision: ROM decode size is inverted
// - A bit1 enables shadow RAM writes
// - A bit2 picks early cache write enable
// - A bit4 picks zero-wait cache write hit
// - A bits6:5 encode cache configuration
// - A bit7 enables caching, zero disables
// - B bits2:0 select installed DRAM size
// - B bits5:4 set CAS wait states
// - B bit6 serves shadow reads from DRAM
// - B bit7 enables DRAM page mode
// - all logic on core clock only
// - inputs ignored until power good high
// - locked shadow: reads local, writes off-board
module ccr_config_regs #(
	parameter int SILICON_REV = 2
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic powerGoodIn,
	input wire logic configSelectN,
	input wire logic writeRead,
	input wire logic memIo,
	input wire logic addrStatusN,
	input wire logic [23:0] cpuAddr,
	input wire logic [7:0] rowAddrConfigDataIn,
	output logic [7:0] rowAddrConfigDataOut,
	output logic rowAddrConfigDataOe,
	output logic cpuClockOut,
	output logic refreshEnable,
	output logic shadowVideoEnable,
	output logic shadowWriteEnable,
	output logic earlyCacheWrite,
	output logic romSize128,
	output logic cacheWriteZeroWait,
	output ccr_pkg::ccr_cache_mode_type cacheMode,
	output logic cacheEnable,
	output logic [2:0] memSize,
	output logic [1:0] casWait,
	output logic shadowReadEnable,
	output logic pageModeEnable,
	output logic biosRomSelectN,
	output logic ioBusCycleN
);
	import ccr_pkg::*;

	// ==========================================================
	// input synchronisers
	// ==========================================================
	localparam int SW = 1 + 1 + 1 + 1 + 1 + 24 + 8;
	// power good idles low so a stale high cannot open the gate after reset
	localparam logic [SW-1:0] SYNC_IDLE = {1'b0, {(SW-1){1'b1}}};
	logic [SW-1:0] pinRaw;
	logic [SW-1:0] syncA_reg;
	logic [SW-1:0] syncB_reg;
	logic cselDly_reg;
	logic adsDly_reg;
	logic pgS, cselNS, wrS, memS, adsNS;
	logic [23:0] addrS;
	logic [7:0] dataS;

	assign pinRaw = {powerGoodIn, configSelectN, writeRead, memIo,
		addrStatusN, cpuAddr, rowAddrConfigDataIn};
	assign {pgS, cselNS, wrS, memS, adsNS, addrS, dataS} = syncB_reg;

	// every pin is asynchronous to the core clock, two flops each
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			syncA_reg <= SYNC_IDLE;
			syncB_reg <= SYNC_IDLE;
		end else if (clkEn) begin
			syncA_reg <= pinRaw;
			syncB_reg <= syncA_reg;
		end
	end

	// third stage for edge detection and the power gate
	logic pgOk_reg;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pgOk_reg <= 1'b0;
			cselDly_reg <= 1'b1;
			adsDly_reg <= 1'b1;
		end else if (clkEn) begin
			pgOk_reg <= pgS;
			cselDly_reg <= cselNS;
			adsDly_reg <= adsNS;
		end
	end

	// strobes and cycle starts only count once power is good
	logic cselFall, cselRise, cycleStart, run;
	assign run = clkEn && pgOk_reg;
	assign cselFall = run && cselDly_reg && !cselNS;
	assign cselRise = run && !cselDly_reg && cselNS;
	assign cycleStart = run && adsDly_reg && !adsNS;

	// ==========================================================
	// feature registers
	// ==========================================================
	logic [7:0] featA_reg;
	logic [7:0] featB_reg;
	logic pairPtr_reg;
	logic [7:0] readData_reg;
	logic readActive_reg;

	// which register the current strobe addresses
	function automatic logic [7:0] readMux(input logic sel,
		input logic [7:0] a, input logic [7:0] b);
		readMux = (sel == FEAT_A_IDX) ? a : b;
	endfunction : readMux

	// writes land on strobe release, when data has settled
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			featA_reg <= FEAT_A_RESET;
			featB_reg <= FEAT_B_RESET;
		end else if (cselRise && wrS) begin
			if (pairPtr_reg == FEAT_A_IDX) begin
				featA_reg <= dataS;
			end else begin
				featB_reg <= dataS & ~(8'h01 << B_RESERVED_BIT);
			end
		end
	end

	// strobe pairing pointer, flips at each strobe end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pairPtr_reg <= FEAT_A_IDX;
		end else if (cselRise) begin
			pairPtr_reg <= ~pairPtr_reg;
		end
	end

	// read data latched at strobe start, driven while strobe low
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			readData_reg <= 8'h00;
			readActive_reg <= 1'b0;
		end else if (cselFall && !wrS) begin
			readData_reg <= readMux(pairPtr_reg, featA_reg, featB_reg);
			readActive_reg <= 1'b1;
		end else if (clkEn && cselNS) begin
			readActive_reg <= 1'b0;
		end
	end

	assign rowAddrConfigDataOut = readData_reg;
	assign rowAddrConfigDataOe = readActive_reg && !cselNS;

	// ==========================================================
	// hidden toggles: refresh and speed
	// ==========================================================
	logic [2:0] refRun_reg;
	logic [2:0] spdRun_reg;
	logic refresh_reg;
	logic speedDiv2_reg;
	logic refHit;

	assign refHit = !memS && !wrS && addrS[15:0] == REFRESH_TOGGLE_PORT;

	// consecutive reads of the refresh port, any other cycle restarts
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			refRun_reg <= 3'h0;
			refresh_reg <= REFRESH_RESET;
		end else if (cycleStart) begin
			if (!refHit) begin
				refRun_reg <= 3'h0;
			end else if (refRun_reg == REFRESH_RUN_LEN - 3'h1) begin
				refRun_reg <= 3'h0;
				refresh_reg <= ~refresh_reg;
			end else begin
				refRun_reg <= refRun_reg + 3'h1;
			end
		end
	end

	// consecutive config reads; a config write breaks the run
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			spdRun_reg <= 3'h0;
			speedDiv2_reg <= SPEED_DIV2_RESET;
		end else if (cselFall) begin
			if (wrS) begin
				spdRun_reg <= 3'h0;
			end else if (spdRun_reg == SPEED_RUN_LEN - 3'h1) begin
				spdRun_reg <= 3'h0;
				speedDiv2_reg <= ~speedDiv2_reg;
			end else begin
				spdRun_reg <= spdRun_reg + 3'h1;
			end
		end
	end

	assign refreshEnable = refresh_reg;

	// ==========================================================
	// cpu clock divider
	// ==========================================================
	logic cpuClk_reg;
	logic divPhase_reg;
	logic activeDiv2_reg;

	// mode only changes while the output is low at a phase boundary,
	// so every high and low half lasts one or two whole periods
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cpuClk_reg <= 1'b0;
			divPhase_reg <= 1'b0;
			activeDiv2_reg <= SPEED_DIV2_RESET;
		end else if (clkEn) begin
			if (!cpuClk_reg && !divPhase_reg) begin
				activeDiv2_reg <= speedDiv2_reg;
			end
			if (!activeDiv2_reg || divPhase_reg) begin
				cpuClk_reg <= ~cpuClk_reg;
				divPhase_reg <= 1'b0;
			end else begin
				divPhase_reg <= 1'b1;
			end
		end
	end

	assign cpuClockOut = cpuClk_reg;

	// ==========================================================
	// decoded feature controls
	// ==========================================================
	assign shadowVideoEnable = featA_reg[A_VIDEO_SHADOW_BIT];
	assign shadowWriteEnable = featA_reg[A_SHADOW_WRITE_BIT];
	assign earlyCacheWrite = featA_reg[A_EARLY_CWR_BIT];
	assign cacheWriteZeroWait = featA_reg[A_CWR_ZERO_WAIT_BIT];
	assign cacheMode = ccr_cache_mode_type'(
		featA_reg[A_CACHE_MODE_LSB +: 2]);
	assign cacheEnable = featA_reg[A_CACHE_EN_BIT];
	assign memSize = featB_reg[B_MEM_SIZE_LSB +: 3];
	assign casWait = featB_reg[B_CAS_WAIT_LSB +: 2];
	assign shadowReadEnable = featB_reg[B_SHADOW_READ_BIT];
	assign pageModeEnable = featB_reg[B_PAGE_MODE_BIT];

	// ==========================================================
	// rom and shadow decode
	// ==========================================================
	logic shadow128;
	logic romDecode128;

	// shadow size follows the bit on both revisions; rom size flips on the first revision
	assign shadow128 = featA_reg[A_ROM_SIZE_BIT];
	assign romDecode128 = (SILICON_REV == 1) ?
		!featA_reg[A_ROM_SIZE_BIT] : featA_reg[A_ROM_SIZE_BIT];
	assign romSize128 = romDecode128;

	// 64K segment, optionally widened by its paired 64K segment (below for rom, above for video) to 128K
	function automatic logic inArea(input logic [7:0] seg,
		input logic [7:0] top, input logic [7:0] low, input logic wide);
		inArea = (seg == top) || (wide && seg == low);
	endfunction : inArea

	logic [7:0] seg;
	logic romArea, biosShadow, videoShadow, shadowArea;
	logic localRead, localWrite;

	assign seg = addrS[23:16];
	assign romArea = inArea(seg, SEG_BIOS, SEG_BIOS_LO, romDecode128) ||
		inArea(seg, SEG_TOP, SEG_TOP_LO, romDecode128);
	assign biosShadow = inArea(seg, SEG_BIOS, SEG_BIOS_LO, shadow128);
	assign videoShadow = featA_reg[A_VIDEO_SHADOW_BIT] &&
		inArea(seg, SEG_VIDEO, SEG_VIDEO_HI, shadow128);
	assign shadowArea = biosShadow || videoShadow;
	assign localRead = !wrS && featB_reg[B_SHADOW_READ_BIT];
	assign localWrite = wrS && featA_reg[A_SHADOW_WRITE_BIT];

	logic romSel_reg;
	logic ioCyc_reg;

	// decode held from one cycle start to the next
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			romSel_reg <= 1'b0;
			ioCyc_reg <= 1'b0;
		end else if (cycleStart) begin
			if (!memS) begin
				romSel_reg <= 1'b0;
				ioCyc_reg <= 1'b1;
			end else if (shadowArea && (localRead || localWrite)) begin
				romSel_reg <= 1'b0;
				ioCyc_reg <= 1'b0;
			end else if (shadowArea && wrS) begin
				romSel_reg <= 1'b0;
				ioCyc_reg <= 1'b1;
			end else begin
				romSel_reg <= romArea;
				ioCyc_reg <= romArea || videoShadow;
			end
		end
	end

	assign biosRomSelectN = ~romSel_reg;
	assign ioBusCycleN = ~ioCyc_reg;
endmodule : ccr_config_regs

// ### test/ccr_config_regs_asserts.sv
`timescale 1ns/1ps
// ==========================================
// checker on the top ports
module ccr_config_regs_checker
	import ccr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic powerGoodIn,
	input wire logic configSelectN,
	input wire logic writeRead,
	input wire logic memIo,
	input wire logic [23:0] cpuAddr,
	input wire logic [7:0] rowAddrConfigDataOut,
	input wire logic rowAddrConfigDataOe,
	input wire logic cpuClockOut,
	input wire logic refreshEnable,
	input wire logic cacheEnable,
	input wire logic [2:0] memSize,
	input wire logic biosRomSelectN,
	input wire logic ioBusCycleN
);
	// one domain: clock and reset given once
	default clocking cb @(posedge sys_clk); endclocking
	// a frozen block keeps its clock output still, so checks pause too
	default disable iff (reset || !clkEn);
	// drive only after a synced read strobe
	property p_oe_rise;
		$rose(rowAddrConfigDataOe) |-> !$past(configSelectN, 3)
			&& !$past(writeRead, 3);
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("data driven without read strobe");
	property p_oe_drop;
		$rose(configSelectN) |-> ##[1:4] !rowAddrConfigDataOe;
	endproperty
	a_oe_drop: assert property (p_oe_drop)
		else $error("data drive not released");
	property p_oe_steady;
		rowAddrConfigDataOe && $past(rowAddrConfigDataOe)
			|-> $stable(rowAddrConfigDataOut);
	endproperty
	a_oe_steady: assert property (p_oe_steady)
		else $error("read data moved during strobe");
	property p_cfg_write;
		$changed({memSize, cacheEnable}) |-> $past(writeRead, 2)
			&& !$past(memIo, 2);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("register changed without write");
	// nothing counts until power is good
	property p_power;
		!powerGoodIn && !$past(powerGoodIn, 4) |-> !rowAddrConfigDataOe
			&& $stable({memSize, cacheEnable, refreshEnable});
	endproperty
	a_power: assert property (p_power)
		else $error("activity while power low");
	property p_refresh;
		$changed(refreshEnable) |-> !$past(memIo, 2) && !$past(writeRead, 2)
			&& $past(cpuAddr[15:0], 2) == REFRESH_TOGGLE_PORT;
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("refresh toggled without port read");
	// halves of one or two cycles only, so no runt or stretch
	property p_clk_half;
		$changed(cpuClockOut) |=> ##[0:1] $changed(cpuClockOut);
	endproperty
	a_clk_half: assert property (p_clk_half)
		else $error("cpu clock half too long");
	property p_rom_decode;
		$fell(biosRomSelectN) |-> $past(memIo, 2)
			&& $past(cpuAddr[23:17], 2) inside {7'h07, 7'h7f};
	endproperty
	a_rom_decode: assert property (p_rom_decode)
		else $error("rom select outside rom area");
	property p_rom_offboard;
		!biosRomSelectN |-> !ioBusCycleN;
	endproperty
	a_rom_offboard: assert property (p_rom_offboard)
		else $error("rom cycle not off-board");
	property p_local;
		$rose(ioBusCycleN) |-> $past(memIo, 2);
	endproperty
	a_local: assert property (p_local)
		else $error("io cycle treated as local");
endmodule : ccr_config_regs_checker

bind ccr_config_regs ccr_config_regs_checker u_checker (.sys_clk, .reset,
	.clkEn, .powerGoodIn, .configSelectN, .writeRead, .memIo, .cpuAddr,
	.rowAddrConfigDataOut, .rowAddrConfigDataOe, .cpuClockOut,
	.refreshEnable, .cacheEnable, .memSize, .biosRomSelectN, .ioBusCycleN);

// ### test/ccr_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host cpu behind the chipset port decoder
module ccr_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] dataBus,
	output logic configSelectN,
	output logic writeRead,
	output logic memIo,
	output logic addrStatusN,
	output logic [23:0] cpuAddr,
	output logic [7:0] hostData
);
	// idle bus at time zero
	initial begin
		configSelectN = 1'b1;
		writeRead = 1'b0;
		memIo = 1'b1;
		addrStatusN = 1'b1;
		cpuAddr = 24'h000000;
		hostData = 8'h00;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : idle
	// cpu cycle; address held well past the synced start
	task automatic cyc(input logic mem, input logic wr, input logic [23:0] a);
		memIo = mem;
		writeRead = wr;
		cpuAddr = a;
		addrStatusN = 1'b0;
		idle(4);
		addrStatusN = 1'b1;
		idle(6);
	endtask : cyc
	// one strobe; data held past the rise since capture is synced
	task automatic access(input logic wr, input logic [7:0] wd,
		output logic [7:0] rd);
		writeRead = wr;
		memIo = 1'b0;
		hostData = wr ? wd : ~hostData;
		configSelectN = 1'b0;
		idle(8);
		rd = dataBus;
		configSelectN = 1'b1;
		idle(6);
		hostData = ~hostData; // released: never the stale value
	endtask : access
	// index write, then two strobes back to back
	task automatic pair(input logic wr, input logic [7:0] a,
		input logic [7:0] b, output logic [7:0] ra, output logic [7:0] rb);
		cyc(1'b0, 1'b1, 24'h000022);
		access(wr, a, ra);
		access(wr, b, rb);
	endtask : pair
endmodule : ccr_host_model

// ### test/testbench.sv
`timescale 1ns/1ps
// ==========================================
// bench: host model talks to the register block
module testbench;
	import ccr_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic clkEn = 1'b1;
	logic powerGoodIn = 1'b0;
	logic configSelectN, writeRead, memIo, addrStatusN;
	logic [23:0] cpuAddr;
	logic [7:0] rowAddrConfigDataIn, rowAddrConfigDataOut, hostData;
	logic rowAddrConfigDataOe, cpuClockOut, refreshEnable, romSize128;
	logic shadowVideoEnable, shadowWriteEnable, earlyCacheWrite;
	logic cacheWriteZeroWait, cacheEnable, shadowReadEnable, pageModeEnable;
	ccr_cache_mode_type cacheMode;
	logic [2:0] memSize;
	logic [1:0] casWait;
	logic biosRomSelectN, ioBusCycleN;
	logic [7:0] a, b, ra, rb;
	int n_mismatch = 0;
	int check_count = 0;
	always #2 sys_clk = ~sys_clk;
	// data pin: device drives on read, host otherwise
	assign rowAddrConfigDataIn = rowAddrConfigDataOe ? rowAddrConfigDataOut
		: hostData;
	ccr_config_regs u_dut (.*);
	ccr_host_model u_host (.sys_clk, .dataBus(rowAddrConfigDataIn),
		.configSelectN, .writeRead, .memIo, .addrStatusN, .cpuAddr, .hostData);
	// first-revision part on the same bus, only its rom size is checked
	logic rev1RomSize128;
	ccr_config_regs #(.SILICON_REV(1)) u_rev1 (.sys_clk, .reset, .clkEn,
		.powerGoodIn, .configSelectN, .writeRead, .memIo, .addrStatusN,
		.cpuAddr, .rowAddrConfigDataIn, .rowAddrConfigDataOut(),
		.rowAddrConfigDataOe(), .cpuClockOut(), .refreshEnable(),
		.shadowVideoEnable(), .shadowWriteEnable(), .earlyCacheWrite(),
		.romSize128(rev1RomSize128), .cacheWriteZeroWait(), .cacheMode(),
		.cacheEnable(), .memSize(), .casWait(), .shadowReadEnable(),
		.pageModeEnable(), .biosRomSelectN(), .ioBusCycleN());
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic fields(input logic [7:0] ea, input logic [7:0] eb);
		cmp({cacheEnable, cacheMode, cacheWriteZeroWait, romSize128,
			earlyCacheWrite, shadowWriteEnable, shadowVideoEnable}, ea);
		cmp({pageModeEnable, shadowReadEnable, casWait, 1'b0, memSize},
			eb & 8'hf7);
		cmp(rev1RomSize128, !ea[A_ROM_SIZE_BIT]);
	endtask : fields
	// count level changes over 16 cycles
	task automatic clkRate(input int exp);
		int n;
		logic last;
		n = 0;
		u_host.idle(6);
		last = cpuClockOut;
		repeat (16) begin
			@(negedge sys_clk);
			n += (cpuClockOut != last);
			last = cpuClockOut;
		end
		cmp(16'(n), 16'(exp));
	endtask : clkRate
	task automatic dec(input logic m, input logic w, input logic [23:0] ad,
		input logic [1:0] exp);
		u_host.cyc(m, w, ad);
		cmp({biosRomSelectN, ioBusCycleN}, exp);
	endtask : dec
	task automatic final_report;
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	// main sequence
	initial begin
		repeat (4) @(negedge sys_clk);
		reset = 1'b0;
		u_host.pair(1'b1, 8'hff, 8'hff, ra, rb);
		repeat (3) u_host.cyc(1'b0, 1'b0, 24'h000822);
		fields(8'h00, 8'h00);
		cmp(refreshEnable, 1'b1);
		powerGoodIn = 1'b1;
		u_host.idle(4);
		fields(8'h00, 8'h00);
		clkRate(16);
		repeat (2) u_host.cyc(1'b0, 1'b0, 24'h000822);
		u_host.cyc(1'b0, 1'b0, 24'h000823);
		repeat (2) u_host.cyc(1'b0, 1'b0, 24'h000822);
		cmp(refreshEnable, 1'b1);
		u_host.cyc(1'b0, 1'b0, 24'h000822);
		cmp(refreshEnable, 1'b0);
		// every mode, size and legal wait code; reserved bit set too
		for (int i = 0; i < 8; i++) begin
			a = {i[2:0], ~i[2:0], i[1:0]};
			b = {i[0], i[1], (i[1:0] == 2'd3) ? 2'b10 : i[1:0], i[2], i[2:0]};
			u_host.pair(1'b1, a, b, ra, rb);
			u_host.pair(1'b0, 8'h00, 8'h00, ra, rb);
			cmp({ra, rb}, {a, b & 8'hf7});
			fields(a, b);
		end
		u_host.pair(1'b1, 8'h09, 8'h40, ra, rb);
		dec(1'b1, 1'b0, 24'h0d1234, 2'b11);
		dec(1'b1, 1'b0, 24'h0e0000, 2'b11);
		dec(1'b1, 1'b1, 24'h0e0000, 2'b10);
		dec(1'b1, 1'b0, 24'hfe0000, 2'b00);
		dec(1'b0, 1'b0, 24'h000300, 2'b10);
		u_host.pair(1'b1, 8'h02, 8'h00, ra, rb);
		dec(1'b1, 1'b1, 24'h0f0000, 2'b11);
		dec(1'b1, 1'b0, 24'h0e0000, 2'b11);
		dec(1'b1, 1'b0, 24'h0f8000, 2'b00);
		repeat (2) u_host.pair(1'b0, 8'h00, 8'h00, ra, rb);
		clkRate(8);
		repeat (2) u_host.pair(1'b0, 8'h00, 8'h00, ra, rb);
		clkRate(16);
		// clock enable low: divider and toggle counters must not move
		clkEn = 1'b0;
		clkRate(0);
		repeat (3) u_host.cyc(1'b0, 1'b0, 24'h000822);
		cmp(refreshEnable, 1'b0);
		clkEn = 1'b1;
		repeat (3) u_host.cyc(1'b0, 1'b0, 24'h000822);
		cmp(refreshEnable, 1'b1);
		reset = 1'b1;
		u_host.idle(4);
		reset = 1'b0;
		u_host.idle(2);
		fields(8'h00, 8'h00);
		final_report();
	end
endmodule : testbench
